// ===== src/pmle_top.sv
// Purpose: line editor for pattern memory: macro copy, block copy, insert
// Assumes: commands held valid until ready; strap stable around reset
// Notes:   one command at a time; output reads stall while busy
//
// Function
// R01: single macro copy writes chosen macro entry to destination line
// R02: macro store is separate; copies only read it
// R03: block copy moves up to sixteen entries, wrapping at top address
// R04: each next macro entry goes to next address; count equals block size
// R05: caller gives single macro index within sixteen entries
// R06: caller gives block start index then stop index
// R07: limit resets to top address of the chosen depth
// R08: standard set restore leaves limit untouched
// R09: two depths supported: 1024 and 16384 lines
// R10: insert writes a zero line after shifting
// R11: lines from address to limit move up; limit line discarded
// R12: lines above limit never touched by insert
// R13: insert refused beyond limit or once repeats exhaust the shiftable lines
// R14: each command runs to completion before next command or output read
`timescale 1ns/1ps
`default_nettype none
module pmle_top (
   input  wire logic                        clk_sys,
   input  wire logic                        srst,
   input  wire logic                        large_variant,
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire pmle_pkg::pmle_req_t         req,
   output logic                             done,
   output logic                             refused,
   output logic                             std_set_pulse,
   output logic      [pmle_pkg::ADDR_W-1:0] limit_addr,
   output logic      [pmle_pkg::ADDR_W-1:0] top_addr,
   input  wire logic                        out_rd_valid,
   output logic                             out_rd_ready,
   input  wire logic [pmle_pkg::ADDR_W-1:0] out_rd_addr,
   output logic                             out_rd_data_valid,
   output logic      [pmle_pkg::DATA_W-1:0] out_rd_data
);
   // ==========================================================
   // state machine
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_MREAD = 3'b001,
      ST_MWRT  = 3'b010,
      ST_SREAD = 3'b011,
      ST_SWRT  = 3'b100,
      ST_ZERO  = 3'b101
   } pmle_state_t;

   pmle_state_t                 state_r;
   logic [pmle_pkg::ADDR_W-1:0] dst_r;
   logic [pmle_pkg::ADDR_W-1:0] ins_r;
   logic [pmle_pkg::MAC_W-1:0]  mac_r;
   logic [pmle_pkg::MAC_W-1:0]  mac_stop_r;
   logic [pmle_pkg::ADDR_W-1:0] limit_r;
   logic [pmle_pkg::ADDR_W-1:0] top_r;
   logic                        strap_s1_r;
   logic                        strap_s2_r;
   logic                        strap_take_r;
   logic                        done_r;
   logic                        refused_r;
   logic                        std_r;
   logic                        rd_pend_r;
   logic [pmle_pkg::DATA_W-1:0] out_data_r;
   logic                        out_valid_r;

   logic [pmle_pkg::DATA_W-1:0] mac_rd;
   logic [pmle_pkg::DATA_W-1:0] main_rd;
   logic [pmle_pkg::ADDR_W-1:0] main_rd_addr;
   pmle_pkg::pmle_wr_t          wr;
   logic                        take;
   logic                        out_take;
   logic                        rep_live_r;
   logic [pmle_pkg::ADDR_W-1:0] rep_addr_r;
   logic [pmle_pkg::ADDR_W-1:0] rep_room_r;
   logic                        rep_hit;
   logic                        ins_refuse;

   // wrap an address inside the active depth
   function automatic logic [pmle_pkg::ADDR_W-1:0] wrap_inc(
      input logic [pmle_pkg::ADDR_W-1:0] a,
      input logic [pmle_pkg::ADDR_W-1:0] top
   );
      wrap_inc = (a == top) ? '0 : a + pmle_pkg::ADDR_ONE;
   endfunction : wrap_inc

   // ==========================================================
   // handshakes: commands and output reads only while idle
   assign req_ready    = (state_r == ST_IDLE);                         // R14
   assign take         = req_valid && req_ready;
   assign out_rd_ready = (state_r == ST_IDLE) && !take;                // R14
   assign out_take     = out_rd_valid && out_rd_ready;

   // ==========================================================
   // insert refusal: beyond the limit, or once repeats at one address
   // have used up every shiftable line between it and the limit
   assign rep_hit    = rep_live_r && (req.addr == rep_addr_r);
   assign ins_refuse = (req.cmd == pmle_pkg::PMLE_CMD_INSERT)
                    && ((req.addr > limit_r) || (rep_hit && rep_room_r == '0)); // R13

   // repeat tracking; a refused repeat keeps it, so exhaustion sticks
   // until some other command or an insert elsewhere starts afresh
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rep_live_r <= 1'b0;
         rep_addr_r <= '0;
         rep_room_r <= '0;
      end else if (take) begin
         if (req.cmd == pmle_pkg::PMLE_CMD_INSERT && !ins_refuse) begin
            rep_live_r <= 1'b1;
            rep_addr_r <= req.addr;
            rep_room_r <= rep_hit ? rep_room_r - pmle_pkg::ADDR_ONE
                                  : limit_r - req.addr;               // R13
         end else if (!(req.cmd == pmle_pkg::PMLE_CMD_INSERT && rep_hit)) begin
            rep_live_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // depth strap, two flops then caught once after reset release
   always_ff @(posedge clk_sys) begin
      strap_s1_r <= large_variant;
      strap_s2_r <= strap_s1_r;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         strap_take_r <= 1'b1;
         top_r        <= pmle_pkg::TOP_LARGE;
      end else if (strap_take_r) begin
         strap_take_r <= 1'b0;
         top_r        <= strap_s2_r ? pmle_pkg::TOP_LARGE : pmle_pkg::TOP_SMALL; // R09
      end
   end

   // ==========================================================
   // limit address: power-up top, standard set leaves it alone
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         limit_r <= pmle_pkg::TOP_LARGE;
      end else if (strap_take_r) begin
         limit_r <= strap_s2_r ? pmle_pkg::TOP_LARGE : pmle_pkg::TOP_SMALL; // R07
      end else if (take && req.cmd == pmle_pkg::PMLE_CMD_SET_LIMIT) begin
         limit_r <= (req.addr > top_r) ? top_r : req.addr;
      end
      // standard set command deliberately absent here                 R08
   end

   // ==========================================================
   // sequencer
   // insert shifts from the limit downward so no line is read after
   // being overwritten; each step costs a read and a write cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_r    <= ST_IDLE;
         dst_r      <= '0;
         ins_r      <= '0;
         mac_r      <= '0;
         mac_stop_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (take) begin
                  dst_r      <= req.addr & top_r;
                  mac_r      <= req.mac_start;                          // R05
                  mac_stop_r <= req.mac_start;
                  ins_r      <= req.addr;
                  case (req.cmd)
                     pmle_pkg::PMLE_CMD_COPY_ONE: begin
                        state_r <= ST_MREAD;                            // R01
                     end
                     pmle_pkg::PMLE_CMD_COPY_BLK: begin
                        mac_stop_r <= req.mac_stop;                     // R06
                        state_r    <= ST_MREAD;
                     end
                     pmle_pkg::PMLE_CMD_INSERT: begin
                        if (!ins_refuse) begin                          // R13
                           dst_r   <= limit_r;                          // R11
                           state_r <= (req.addr == limit_r) ? ST_ZERO : ST_SREAD;
                        end
                     end
                     default: begin
                        state_r <= ST_IDLE;
                     end
                  endcase
               end
            end
            ST_MREAD: begin
               state_r <= ST_MWRT;
            end
            ST_MWRT: begin
               if (mac_r == mac_stop_r) begin                           // R04
                  state_r <= ST_IDLE;
               end else begin
                  mac_r   <= mac_r + pmle_pkg::MAC_ONE;
                  dst_r   <= wrap_inc(dst_r, top_r);                    // R03
                  state_r <= ST_MREAD;
               end
            end
            ST_SREAD: begin
               state_r <= ST_SWRT;
            end
            ST_SWRT: begin
               dst_r   <= dst_r - pmle_pkg::ADDR_ONE;
               state_r <= (dst_r - pmle_pkg::ADDR_ONE == ins_r) ? ST_ZERO : ST_SREAD;
            end
            ST_ZERO: begin
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // memory port steering
   always_comb begin
      wr.we        = 1'b0;
      wr.addr      = dst_r;
      wr.data      = mac_rd;
      main_rd_addr = out_rd_addr;
      case (state_r)
         ST_MWRT: begin
            wr.we = 1'b1;                                               // R01
         end
         ST_SREAD: begin
            main_rd_addr = dst_r - pmle_pkg::ADDR_ONE;                  // R11
         end
         ST_SWRT: begin
            wr.we   = 1'b1;                                             // R12
            wr.data = main_rd;
         end
         ST_ZERO: begin
            wr.we   = 1'b1;
            wr.addr = ins_r;
            wr.data = pmle_pkg::ZERO_LINE;                              // R10
         end
         default: begin
            if (take && req.cmd == pmle_pkg::PMLE_CMD_MAIN_WR) begin
               wr.we   = 1'b1;
               wr.addr = req.addr & top_r;
               wr.data = req.data;
            end
         end
      endcase
   end

   // ==========================================================
   // memories; macro store written only by its own command
   pmle_macro_mem u_mac (                                               // R02
      .clk_sys (clk_sys),
      .wr_en   (take && req.cmd == pmle_pkg::PMLE_CMD_MAC_WR),
      .wr_idx  (req.mac_start),
      .wr_data (req.data),
      .rd_idx  (mac_r),
      .rd_data (mac_rd)
   );

   pmle_main_mem u_main (
      .clk_sys (clk_sys),
      .wr      (wr),
      .rd_addr (main_rd_addr),
      .rd_data (main_rd)
   );

   // ==========================================================
   // status pulses
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         done_r    <= 1'b0;
         refused_r <= 1'b0;
         std_r     <= 1'b0;
      end else begin
         done_r    <= (state_r == ST_ZERO)
                   || (state_r == ST_MWRT && mac_r == mac_stop_r)
                   || (take && (req.cmd == pmle_pkg::PMLE_CMD_SET_LIMIT
                             || req.cmd == pmle_pkg::PMLE_CMD_STD_SET
                             || req.cmd == pmle_pkg::PMLE_CMD_MAC_WR
                             || req.cmd == pmle_pkg::PMLE_CMD_MAIN_WR
                             || req.cmd == pmle_pkg::PMLE_CMD_NONE));
         refused_r <= take && ins_refuse;                               // R13
         std_r     <= take && req.cmd == pmle_pkg::PMLE_CMD_STD_SET;
      end
   end

   // ==========================================================
   // output read path, two-cycle latency after acceptance
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rd_pend_r   <= 1'b0;
         out_valid_r <= 1'b0;
         out_data_r  <= '0;
      end else begin
         rd_pend_r   <= out_take;
         out_valid_r <= rd_pend_r;
         if (rd_pend_r) begin
            out_data_r <= main_rd;
         end
      end
   end

   assign done              = done_r;
   assign refused           = refused_r;
   assign std_set_pulse     = std_r;
   assign limit_addr        = limit_r;
   assign top_addr          = top_r;
   assign out_rd_data_valid = out_valid_r;
   assign out_rd_data       = out_data_r;
endmodule : pmle_top
`default_nettype wire

// ===== src/pmle_pkg.sv
// Purpose: shared constants and types for the pattern memory line editor
// Assumes: one system clock, synchronous active-high reset
// Notes:   depth chosen by the large_variant strap captured after reset
package pmle_pkg;
   // ==========================================================
   // sizes
   localparam int unsigned DATA_W      = 16;
   localparam int unsigned ADDR_W      = 14;
   localparam int unsigned MAC_W       = 4;
   localparam int unsigned MAIN_DEPTH  = 16384;
   localparam logic [ADDR_W-1:0] TOP_LARGE = 14'h3FFF;
   localparam logic [ADDR_W-1:0] TOP_SMALL = 14'h03FF;
   localparam logic [DATA_W-1:0] ZERO_LINE = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ONE  = 14'h0001;
   localparam logic [MAC_W-1:0]  MAC_ONE   = 4'h1;

   // ==========================================================
   // commands
   typedef enum logic [2:0] {
      PMLE_CMD_NONE      = 3'h0,
      PMLE_CMD_COPY_ONE  = 3'h1,
      PMLE_CMD_COPY_BLK  = 3'h2,
      PMLE_CMD_INSERT    = 3'h3,
      PMLE_CMD_SET_LIMIT = 3'h4,
      PMLE_CMD_STD_SET   = 3'h5,
      PMLE_CMD_MAC_WR    = 3'h6,
      PMLE_CMD_MAIN_WR   = 3'h7
   } pmle_cmd_t;

   typedef struct packed {
      pmle_cmd_t         cmd;
      logic [ADDR_W-1:0] addr;      // destination / insert / limit / write addr
      logic [MAC_W-1:0]  mac_start; // macro index (single) or block start
      logic [MAC_W-1:0]  mac_stop;  // block stop
      logic [DATA_W-1:0] data;      // write data for direct writes
   } pmle_req_t;

   typedef struct packed {
      logic              we;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } pmle_wr_t;
endpackage : pmle_pkg

// ===== src/pmle_macro_mem.sv
// Purpose: sixteen-entry macro line store, separate from main memory
// Assumes: written only by explicit macro write commands
// Notes:   registered read, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module pmle_macro_mem (
   input  wire logic                        clk_sys,
   input  wire logic                        wr_en,
   input  wire logic [pmle_pkg::MAC_W-1:0]  wr_idx,
   input  wire logic [pmle_pkg::DATA_W-1:0] wr_data,
   input  wire logic [pmle_pkg::MAC_W-1:0]  rd_idx,
   output logic      [pmle_pkg::DATA_W-1:0] rd_data
);
   // ==========================================================
   // storage
   logic [pmle_pkg::DATA_W-1:0] mem [16];

   // write port only from macro write, never from copy
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   // read port
   always_ff @(posedge clk_sys) begin
      rd_data <= mem[rd_idx];
   end
endmodule : pmle_macro_mem
`default_nettype wire

// ===== src/pmle_main_mem.sv
// Purpose: main pattern memory, one write and one read port
// Assumes: full large depth built; small variant uses low addresses
// Notes:   registered read, one cycle latency, no reset of contents
`timescale 1ns/1ps
`default_nettype none
module pmle_main_mem (
   input  wire logic                        clk_sys,
   input  wire pmle_pkg::pmle_wr_t          wr,
   input  wire logic [pmle_pkg::ADDR_W-1:0] rd_addr,
   output logic      [pmle_pkg::DATA_W-1:0] rd_data
);
   // ==========================================================
   // storage
   logic [pmle_pkg::DATA_W-1:0] mem [pmle_pkg::MAIN_DEPTH];

   // write port
   always_ff @(posedge clk_sys) begin
      if (wr.we) begin
         mem[wr.addr] <= wr.data;
      end
   end

   // read port
   always_ff @(posedge clk_sys) begin
      rd_data <= mem[rd_addr];
   end
endmodule : pmle_main_mem
`default_nettype wire

// ===== verif/pmle_top_asserts.sv
// Purpose: port-level checks for the line editor
// Assumes: one clock, synchronous active-high reset
// Notes:   latencies are those of the hand-over contract
`timescale 1ns/1ps
`default_nettype none
module pmle_top_asserts (
   input wire logic                clk_sys,
   input wire logic                srst,
   input wire logic                large_variant,
   input wire logic                req_valid,
   input wire logic                req_ready,
   input wire pmle_pkg::pmle_req_t req,
   input wire logic                done,
   input wire logic                refused,
   input wire logic                std_set_pulse,
   input wire logic [13:0]         limit_addr,
   input wire logic [13:0]         top_addr,
   input wire logic                out_rd_valid,
   input wire logic                out_rd_ready,
   input wire logic [13:0]         out_rd_addr,
   input wire logic                out_rd_data_valid,
   input wire logic [15:0]         out_rd_data
);
   // ==========
   // acceptance helpers
   logic                take;
   logic                rd_take;
   pmle_pkg::pmle_cmd_t cmd;
   logic                ins_prev_live_r;
   logic [13:0]         ins_prev_r;
   assign take    = req_valid && req_ready;
   assign rd_take = out_rd_valid && out_rd_ready;
   assign cmd     = req.cmd;

   // whether the last accepted command was an insert, and where
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ins_prev_live_r <= 1'b0;
         ins_prev_r      <= '0;
      end else if (take) begin
         ins_prev_live_r <= (cmd == pmle_pkg::PMLE_CMD_INSERT);
         ins_prev_r      <= req.addr;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   // ==========
   // properties
   chk_one_latency: assert property (take && cmd == pmle_pkg::PMLE_CMD_COPY_ONE
      |=> !done [*2] ##1 done) else $error("single copy latency wrong");
   chk_direct_done: assert property (take && (cmd == pmle_pkg::PMLE_CMD_NONE
      || cmd >= pmle_pkg::PMLE_CMD_SET_LIMIT) |=> done) else $error("direct done missing");
   chk_ins_refuse: assert property (take && cmd == pmle_pkg::PMLE_CMD_INSERT
      && req.addr > limit_addr |=> refused && !done) else $error("insert not refused");
   chk_ins_allowed: assert property (take && cmd == pmle_pkg::PMLE_CMD_INSERT
      && req.addr <= limit_addr && !(ins_prev_live_r && req.addr == ins_prev_r)
      |=> !refused) else $error("insert wrongly refused");
   chk_blk_busy: assert property (take && cmd == pmle_pkg::PMLE_CMD_COPY_BLK
      |=> !req_ready [*2]) else $error("ready during block copy");
   chk_rd_latency: assert property (rd_take |-> ##2 out_rd_data_valid)
      else $error("read data late");
   chk_rd_idle: assert property (out_rd_ready |-> req_ready && !take)
      else $error("read taken while busy");
   chk_std_keep: assert property (take && cmd == pmle_pkg::PMLE_CMD_STD_SET
      |=> $stable(limit_addr) [*2]) else $error("limit moved on standard set");
   chk_top_value: assert property (top_addr == 14'h3FFF || top_addr == 14'h03FF)
      else $error("top address not a depth");
   chk_pulse_excl: assert property (!(done && refused))
      else $error("done with refused");

   // cover the main traffic
   cover property (take && cmd == pmle_pkg::PMLE_CMD_COPY_BLK);
   cover property (refused);
   cover property (rd_take);
   cover property (take && cmd == pmle_pkg::PMLE_CMD_INSERT && req.addr <= limit_addr
      ##1 refused);
endmodule : pmle_top_asserts

bind pmle_top pmle_top_asserts i_chk (.clk_sys(clk_sys), .srst(srst),
   .large_variant(large_variant), .req_valid(req_valid), .req_ready(req_ready),
   .req(req), .done(done), .refused(refused), .std_set_pulse(std_set_pulse),
   .limit_addr(limit_addr), .top_addr(top_addr), .out_rd_valid(out_rd_valid),
   .out_rd_ready(out_rd_ready), .out_rd_addr(out_rd_addr),
   .out_rd_data_valid(out_rd_data_valid), .out_rd_data(out_rd_data));
`default_nettype wire

// ===== verif/testbench.sv
// Purpose: self-checking bench for the line editor
// Assumes: shadow memory model mirrors every command
// Notes:   fixed stimulus, both depth straps exercised
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam pmle_pkg::pmle_cmd_t C_NONE = pmle_pkg::PMLE_CMD_NONE;
   localparam pmle_pkg::pmle_cmd_t C_ONE  = pmle_pkg::PMLE_CMD_COPY_ONE;
   localparam pmle_pkg::pmle_cmd_t C_BLK  = pmle_pkg::PMLE_CMD_COPY_BLK;
   localparam pmle_pkg::pmle_cmd_t C_INS  = pmle_pkg::PMLE_CMD_INSERT;
   localparam pmle_pkg::pmle_cmd_t C_LIM  = pmle_pkg::PMLE_CMD_SET_LIMIT;
   localparam pmle_pkg::pmle_cmd_t C_STD  = pmle_pkg::PMLE_CMD_STD_SET;
   localparam pmle_pkg::pmle_cmd_t C_MAC  = pmle_pkg::PMLE_CMD_MAC_WR;
   localparam pmle_pkg::pmle_cmd_t C_MAIN = pmle_pkg::PMLE_CMD_MAIN_WR;
   logic clk_sys, srst, large_variant, req_valid, req_ready, done, refused, std_set_pulse;
   logic out_rd_valid, out_rd_ready, out_rd_data_valid, rlive;
   logic [13:0] limit_addr, top_addr, out_rd_addr, lim, top, raddr, rroom;
   logic [15:0] out_rd_data;
   logic [15:0] mm [0:16383];
   logic [15:0] mac [0:15];
   pmle_pkg::pmle_req_t req;
   int n_fail, n_compared, i;
   // ordinary cases, one command per row
   pmle_pkg::pmle_req_t rows [14] = '{
      '{C_LIM, 14'h0008, 4'h0, 4'h0, '0}, '{C_ONE, 14'h0002, 4'h5, 4'h0, '0},
      '{C_BLK, 14'h3FFE, 4'hE, 4'h1, '0}, '{C_BLK, 14'h0100, 4'h0, 4'hF, '0},
      '{C_BLK, 14'h001F, 4'h7, 4'h7, '0}, '{C_INS, 14'h0004, 4'h0, 4'h0, '0},
      '{C_INS, 14'h0006, 4'h0, 4'h0, '0}, '{C_INS, 14'h0006, 4'h0, 4'h0, '0},
      '{C_INS, 14'h0006, 4'h0, 4'h0, '0}, '{C_INS, 14'h0006, 4'h0, 4'h0, '0},
      '{C_INS, 14'h0009, 4'h0, 4'h0, '0}, '{C_STD, 14'h0000, 4'h0, 4'h0, '0},
      '{C_INS, 14'h0008, 4'h0, 4'h0, '0}, '{C_NONE, 14'h0000, 4'h0, 4'h0, '0}};

   pmle_top i_dut (.clk_sys(clk_sys), .srst(srst), .large_variant(large_variant),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
      .refused(refused), .std_set_pulse(std_set_pulse), .limit_addr(limit_addr),
      .top_addr(top_addr), .out_rd_valid(out_rd_valid), .out_rd_ready(out_rd_ready),
      .out_rd_addr(out_rd_addr), .out_rd_data_valid(out_rd_data_valid),
      .out_rd_data(out_rd_data));

   // ==========
   // helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic give_verdict;
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   // addresses that get seeded and read back
   function automatic logic [13:0] aof(input int k);
      if (k < 32) return 14'(k);
      if (k < 48) return 14'(k + 224);
      return 14'h3FFE + 14'(k - 48);
   endfunction : aof

   // strap must settle before release, so it is set with reset high
   task automatic do_reset(input logic big);
      @(posedge clk_sys);
      #1;
      large_variant = big;
      srst = 1'b1;
      repeat (4) @(posedge clk_sys);
      #1 srst = 1'b0;
      top = big ? pmle_pkg::TOP_LARGE : pmle_pkg::TOP_SMALL;
      lim = top;
      rlive = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(16'(top_addr), 16'(top));
      chk(16'(limit_addr), 16'(lim));
   endtask : do_reset

   // one command: expected latency and shadow update come from the model
   task automatic run(input pmle_pkg::pmle_cmd_t c, input logic [13:0] a,
                      input logic [3:0] s, input logic [3:0] e, input logic [15:0] d);
      int k, n, el;
      logic rf, rs, sp, rhit;
      n    = int'(4'(e - s)) + 1;
      rhit = rlive && (a == raddr);
      rf   = (c == C_INS) && ((a > lim) || (rhit && rroom == 14'h0000));
      case (c)
         C_ONE:   el = 3;
         C_BLK:   el = 2 * n + 1;
         C_INS:   el = rf ? 1 : 2 * int'(lim - a) + 2;
         default: el = 1;
      endcase
      @(posedge clk_sys);
      #1;
      req = '{c, a, s, e, d};
      req_valid = 1'b1;
      k = 0;
      do @(negedge clk_sys); while (req_ready !== 1'b1 && ++k < 99);
      chk(16'(k < 99), 16'h0001);
      @(posedge clk_sys);
      #1 req_valid = 1'b0;
      sp = 1'b0;
      for (k = 1; k < 99; k++) begin
         @(negedge clk_sys);
         sp |= std_set_pulse;
         if (done === 1'b1 || refused === 1'b1) break;
      end
      rs = refused;
      @(negedge clk_sys);
      sp |= std_set_pulse;
      case (c)
         C_MAC:  mac[s] = d;
         C_MAIN: mm[a & top] = d;
         C_ONE:  mm[a & top] = mac[s];
         C_BLK:  for (i = 0; i < n; i++) mm[(a + 14'(i)) & top] = mac[s + 4'(i)];
         C_INS:  if (!rf) begin
            for (i = int'(lim); i > int'(a); i--) mm[i] = mm[i - 1];
            mm[a] = pmle_pkg::ZERO_LINE;
         end
         C_LIM:  lim = (a > top) ? top : a;
         default: ;
      endcase
      // repeats at one address may only use the lines up to the limit
      if (c == C_INS && !rf) begin
         rroom = rhit ? rroom - 14'h0001 : lim - a;
         raddr = a;
         rlive = 1'b1;
      end else if (!(c == C_INS && rhit)) begin
         rlive = 1'b0;
      end
      chk(16'(k), 16'(el));
      chk(16'(rs), 16'(rf));
      chk(16'(sp), 16'(c == C_STD));
      chk(16'(limit_addr), 16'(lim));
   endtask : run

   task automatic rd(input logic [13:0] a, input logic [15:0] x);
      int k;
      @(posedge clk_sys);
      #1;
      out_rd_valid = 1'b1;
      out_rd_addr = a;
      k = 0;
      do @(negedge clk_sys); while (out_rd_ready !== 1'b1 && ++k < 99);
      chk(16'(k < 99), 16'h0001);
      @(posedge clk_sys);
      #1 out_rd_valid = 1'b0;
      repeat (2) @(negedge clk_sys);
      chk(16'(out_rd_data_valid), 16'h0001);
      chk(out_rd_data, x);
   endtask : rd

   // ==========
   // clock, watchdog, sequence
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // generous bound: the sequence needs several hundred cycles
   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end

   initial begin
      n_fail = 0; n_compared = 0; srst = 1'b1; large_variant = 1'b1; req_valid = 1'b0;
      req = '0; out_rd_valid = 1'b0; out_rd_addr = '0;
      do_reset(1'b1);
      for (int m = 0; m < 16; m++) run(C_MAC, '0, 4'(m), '0, 16'hA000 + 16'(m));
      for (int m = 0; m < 50; m++) run(C_MAIN, aof(m), '0, '0, 16'h5000 ^ 16'(aof(m)));
      foreach (rows[r]) run(rows[r].cmd, rows[r].addr, rows[r].mac_start, rows[r].mac_stop,
                            rows[r].data);
      for (int m = 0; m < 50; m++) rd(aof(m), mm[aof(m)]);
      // read queued behind a copy must see the copied line
      fork
         run(C_ONE, 14'h0010, 4'h3, 4'h0, '0);
         rd(14'h0010, mac[3]);
      join
      do_reset(1'b0);
      run(C_LIM, 14'h3FFF, '0, '0, '0);
      run(C_BLK, 14'h03FF, 4'h2, 4'h3, '0);
      rd(14'h03FF, mac[2]);
      rd(14'h0000, mac[3]);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
